// >>> src/tcr_top.sv
`timescale 1ns/1ps
`include "tcr_params.svh"

module tcr_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [`TCR_AW-1:0] adr_i,
  input wire logic [`TCR_DW-1:0] dat_i,
  input wire logic [`TCR_SW-1:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [`TCR_DW-1:0] dat_o,
  output logic ack_o,
  // Timers
  input wire logic [`TCR_NTMR-1:0][`TCR_CW-1:0] counter_value_i,
  input wire logic [`TCR_NTMR-1:0] counter_tick_i,
  input wire logic [`TCR_NTMR-1:0] counter_write_i,
  input wire logic [`TCR_NTMR-1:0] pwm_mode_i,
  // Compare results
  output logic [`TCR_NCH-1:0] compare_output_pin_o,
  output logic [`TCR_NCH-1:0] compare_match_o,
  output logic irq_o
);

  // ********************************************************************
  // Register map
  // ********************************************************************
  // Entry k of both tables is channel k, which is also bit k of force, status and mask.
  localparam logic [`TCR_IW-1:0] LO_IDX [`TCR_NCH] = '{
    `TCR_T1A_LO,
    `TCR_T1B_LO,
    `TCR_T1C_LO,
    `TCR_T3A_LO,
    `TCR_T3B_LO,
    `TCR_T3C_LO,
    `TCR_T4A_LO,
    `TCR_T4B_LO,
    `TCR_T4C_LO,
    `TCR_T5A_LO,
    `TCR_T5B_LO,
    `TCR_T5C_LO
  };
  localparam logic [`TCR_IW-1:0] HI_IDX [`TCR_NCH] = '{
    `TCR_T1A_HI,
    `TCR_T1B_HI,
    `TCR_T1C_HI,
    `TCR_T3A_HI,
    `TCR_T3B_HI,
    `TCR_T3C_HI,
    `TCR_T4A_HI,
    `TCR_T4B_HI,
    `TCR_T4C_HI,
    `TCR_T5A_HI,
    `TCR_T5B_HI,
    `TCR_T5C_HI
  };

  tcr_pkg::tcr_top_s st_q;
  tcr_pkg::tcr_top_s st_d;

  logic req;
  logic commit;
  logic [`TCR_IW-1:0] idx;
  logic [`TCR_NCH-1:0] lo_hit;
  logic [`TCR_NCH-1:0] hi_hit;
  logic [`TCR_NCH-1:0] wr_ch;
  logic [`TCR_NCH-1:0] force_ch;
  logic [`TCR_NCH-1:0] clr_bits;
  logic [`TCR_NCH-1:0][`TCR_CW-1:0] cmp_val;
  logic [`TCR_CW-1:0] wr_value;
  logic [`TCR_DW-1:0] rd_data;
  logic hit_force;
  logic hit_stat;
  logic hit_mask;
  logic mapped;

  assign req = cyc_i & stb_i;
  assign idx = adr_i[`TCR_AW-1:`TCR_IDX_LSB];
  assign hit_force = (idx == `TCR_FORCE_IDX);
  assign hit_stat = (idx == `TCR_STAT_IDX);
  assign hit_mask = (idx == `TCR_MASK_IDX);
  assign mapped = (|lo_hit) | (|hi_hit) | hit_force | hit_stat | hit_mask;

  // Writes land on the edge that also shows the master our ack.
  assign commit = (st_q.bus == tcr_pkg::TCR_BUS_ACK) & req & we_i & sel_i[0];

  // The low byte write carries the latched high byte with it.
  assign wr_value = {st_q.temp, dat_i[`TCR_BW-1:0]};

  // ********************************************************************
  // Compare channels
  // ********************************************************************
  genvar k;
  generate
    for (k = 0; k < `TCR_NCH; k++)
    begin : g_chan
      localparam int TMR = k / `TCR_NCHT;

      assign lo_hit[k] = (idx == LO_IDX[k]);
      assign hi_hit[k] = (idx == HI_IDX[k]);
      assign wr_ch[k] = commit & lo_hit[k];
      assign force_ch[k] = commit & hit_force & dat_i[k];

      tcr_cmp_chan u_chan
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .counter_value_i(counter_value_i[TMR]),
        .counter_tick_i(counter_tick_i[TMR]),
        .counter_write_i(counter_write_i[TMR]),
        .pwm_mode_i(pwm_mode_i[TMR]),
        .force_compare_strobe_i(force_ch[k]),
        .wr_i(wr_ch[k]),
        .wr_value_i(wr_value),
        .compare_value_o(cmp_val[k]),
        .compare_match_o(compare_match_o[k]),
        .compare_output_pin_o(compare_output_pin_o[k])
      );
    end
  endgenerate

  // ********************************************************************
  // Read data
  // ********************************************************************
  always_comb
  begin
    rd_data = '0;
    for (int i = 0; i < `TCR_NCH; i++)
    begin
      if (lo_hit[i])
      begin
        rd_data[`TCR_BW-1:0] = cmp_val[i][`TCR_BW-1:0];
      end
      if (hi_hit[i])
      begin
        rd_data[`TCR_BW-1:0] = cmp_val[i][`TCR_CW-1:`TCR_BW];
      end
    end
    // The force register is a strobe and always reads back as zero.
    if (hit_stat)
    begin
      rd_data[`TCR_NCH-1:0] = st_q.status;
    end
    if (hit_mask)
    begin
      rd_data[`TCR_NCH-1:0] = st_q.mask;
    end
  end

  // ********************************************************************
  // Bus, holding latch and interrupt flags
  // ********************************************************************
  assign clr_bits = (commit && hit_stat) ? dat_i[`TCR_NCH-1:0] : `TCR_RST_FLAGS;

  always_comb
  begin
    st_d = st_q;
    case (st_q.bus)
      tcr_pkg::TCR_BUS_IDLE:
      begin
        if (req)
        begin
          st_d.bus = tcr_pkg::TCR_BUS_ACK;
          st_d.dat = rd_data;
        end
      end
      tcr_pkg::TCR_BUS_ACK:
      begin
        st_d.bus = tcr_pkg::TCR_BUS_IDLE;
      end
      default:
      begin
        st_d.bus = tcr_pkg::TCR_BUS_IDLE;
      end
    endcase
    // Any high byte write reloads the one shared latch, even mid-sequence.
    if (commit && (|hi_hit))
    begin
      st_d.temp = dat_i[`TCR_BW-1:0];
    end
    if (commit && hit_mask)
    begin
      st_d.mask = dat_i[`TCR_NCH-1:0];
    end
    // A match that coincides with a clear survives it.
    st_d.status = (st_q.status & ~clr_bits) | compare_match_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '{bus: tcr_pkg::TCR_BUS_IDLE, dat: '0, temp: `TCR_RST_BYTE,
                status: `TCR_RST_FLAGS, mask: `TCR_RST_FLAGS};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign ack_o = (st_q.bus == tcr_pkg::TCR_BUS_ACK);
  assign dat_o = st_q.dat;
  assign irq_o = |(st_q.status & st_q.mask);

  // ********************************************************************
  // Assertions
  // ********************************************************************
  ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  ack_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack_o) |=> ack_o)
    else $error("request not answered in one cycle");

  latch_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && (|hi_hit)) |=> (st_q.temp == $past(dat_i[`TCR_BW-1:0])))
    else $error("high byte write did not load the holding latch");

  pair_commit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && lo_hit[0]) |=> (cmp_val[0] == {$past(st_q.temp), $past(dat_i[`TCR_BW-1:0])}))
    else $error("low byte write did not commit both bytes");

  high_only_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && hi_hit[0]) |=> $stable(cmp_val[0]))
    else $error("high byte write changed the compare value");

  flag_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    compare_match_o[0] |=> st_q.status[0])
    else $error("match did not set the flag");

  irq_from_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (compare_match_o[0] && st_q.mask[0] && !(commit && hit_mask)) |=> irq_o)
    else $error("unmasked match did not raise the interrupt");

  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && hit_stat && dat_i[0] && !compare_match_o[0]) |=> !st_q.status[0])
    else $error("write one did not clear the flag");

  unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack_o && !mapped) |=> (dat_o == '0))
    else $error("unmapped read returned nonzero data");

  pin_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
    compare_match_o[0] |-> (compare_output_pin_o[0] != $past(compare_output_pin_o[0])))
    else $error("match did not change the output pin");

  cover_pair_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
    (commit && hi_hit[0]) ##[1:8] (commit && lo_hit[0]));

  cover_match_irq_c: cover property (@(posedge clk_i) disable iff (rst_i)
    compare_match_o[0] ##1 irq_o);

  cover_force_c: cover property (@(posedge clk_i) disable iff (rst_i)
    (force_ch != '0));

  cover_blank_tick_c: cover property (@(posedge clk_i) disable iff (rst_i)
    counter_write_i[0] ##1 (counter_tick_i[0] && !counter_write_i[0]));

  cover_flag_clear_c: cover property (@(posedge clk_i) disable iff (rst_i)
    (commit && hit_stat));

  mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && hit_mask) |=> (st_q.mask == $past(dat_i[`TCR_NCH-1:0])))
    else $error("mask write did not land");

  force_reads_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack_o && hit_force) |=> (dat_o == '0))
    else $error("force register did not read as zero");

  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack_o && hit_stat)
      |=> (dat_o == {{(`TCR_DW-`TCR_NCH){1'b0}}, $past(st_q.status)}))
    else $error("status read returned wrong data");

  latch_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(commit && (|hi_hit)) |=> $stable(st_q.temp))
    else $error("holding latch changed without a high byte write");

  sel_refused_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_o && req && we_i && !sel_i[0])
      |=> ($stable(cmp_val) && $stable(st_q.mask) && $stable(st_q.temp)))
    else $error("write without byte enable changed a register");

  ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !ack_o)
    else $error("ack given without a request");

  dat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && !ack_o) |=> $stable(dat_o))
    else $error("read data changed without a new request");

  // ********************************************************************
  // Per-channel checks
  // ********************************************************************
  // Channel 0 alone would leave the table entries and bit positions of
  // the other eleven channels unguarded, so every channel gets its own set.
  genvar c;
  generate
    for (c = 0; c < `TCR_NCH; c++)
    begin : g_chk
      localparam int TM = c / `TCR_NCHT;

      flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.status[c] && !(commit && hit_stat && dat_i[c])) |=> st_q.status[c])
        else $error("compare flag dropped without a clear");

      // A forced match must not reach the flag, only a real one may.
      flag_no_spur_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_q.status[c] && !compare_match_o[c]) |=> !st_q.status[c])
        else $error("compare flag set without a match");

      set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (commit && hit_stat && dat_i[c] && compare_match_o[c]) |=> st_q.status[c])
        else $error("clear beat a coinciding match");

      value_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(commit && lo_hit[c]) |=> $stable(cmp_val[c]))
        else $error("compare value changed without a low byte write");

      read_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !ack_o && lo_hit[c])
          |=> (dat_o == {{(`TCR_DW-`TCR_BW){1'b0}}, $past(cmp_val[c][`TCR_BW-1:0])}))
        else $error("low byte read returned wrong data");

      read_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !ack_o && hi_hit[c])
          |=> (dat_o == {{(`TCR_DW-`TCR_BW){1'b0}}, $past(cmp_val[c][`TCR_CW-1:`TCR_BW])}))
        else $error("high byte read returned wrong data");

      match_needs_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        compare_match_o[c] |-> ($past(counter_tick_i[TM])
          && ($past(counter_value_i[TM]) == $past(cmp_val[c]))))
        else $error("match without an equal counter on a tick");

      pin_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (compare_output_pin_o[c] != $past(compare_output_pin_o[c]))
          |-> (compare_match_o[c] || $past(force_ch[c])))
        else $error("output pin changed without a match or force");

      // A timer in a PWM mode owns its pins, so a stray strobe must not disturb them.
      pwm_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (force_ch[c] && pwm_mode_i[TM])
          |=> (compare_match_o[c] || $stable(compare_output_pin_o[c])))
        else $error("force strobe acted in a PWM mode");
    end
  endgenerate

endmodule

// >>> src/tcr_params.svh
// Operation
// - Each channel holds a 16-bit compare value that is checked against its timer's counter on every counter state.
// - A counter equal to a channel's compare value is offered as that channel's compare interrupt request.
// - A compare match also changes the waveform on the channel's own compare output pin.
// - A compare value write updates its high and low bytes in one cycle, the high byte coming from an 8-bit holding latch.
// - One holding latch serves every 16-bit register, so an access to any of them may overwrite it.
// - A write to a counter removes any compare match of all that timer's channels on its next timer clock.
// - A channel's compare match flag is set in the timer clock cycle after the counter equals the compare value.
// - A one written to a channel's force strobe outside the PWM modes forces a match on its waveform only.
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// ********************************************************************
// Sizes
// ********************************************************************
`define TCR_NTMR 4
`define TCR_NCHT 3
`define TCR_NCH 12
`define TCR_CW 16
`define TCR_BW 8
`define TCR_DW 32
`define TCR_SW 4
`define TCR_AW 11
`define TCR_IW 9
`define TCR_IDX_LSB 2

// ********************************************************************
// Register indices; the byte address is four times the index
// ********************************************************************
`define TCR_T1A_LO 9'h088
`define TCR_T1A_HI 9'h089
`define TCR_T1B_LO 9'h08a
`define TCR_T1B_HI 9'h08b
`define TCR_T1C_LO 9'h08c
`define TCR_T1C_HI 9'h08d
`define TCR_T3A_LO 9'h098
`define TCR_T3A_HI 9'h099
`define TCR_T3B_LO 9'h09a
`define TCR_T3B_HI 9'h09b
`define TCR_T3C_LO 9'h09c
`define TCR_T3C_HI 9'h09d
`define TCR_T4A_LO 9'h0a8
`define TCR_T4A_HI 9'h0a9
`define TCR_T4B_HI 9'h0aa
`define TCR_T4B_LO 9'h0ab
`define TCR_T4C_LO 9'h0ac
`define TCR_T4C_HI 9'h0ad
`define TCR_T5A_LO 9'h128
`define TCR_T5A_HI 9'h129
`define TCR_T5B_LO 9'h12a
`define TCR_T5B_HI 9'h12b
`define TCR_T5C_LO 9'h12c
`define TCR_T5C_HI 9'h12d
`define TCR_FORCE_IDX 9'h130
`define TCR_STAT_IDX 9'h131
`define TCR_MASK_IDX 9'h132

// ********************************************************************
// Reset values
// ********************************************************************
`define TCR_RST_VAL 16'h0000
`define TCR_RST_BYTE 8'h00
`define TCR_RST_FLAGS 12'h000

`endif

// >>> src/tcr_pkg.sv
`include "tcr_params.svh"

package tcr_pkg;

  typedef enum logic [1:0]
  {
    TCR_BUS_IDLE = 2'b00,
    TCR_BUS_ACK = 2'b01
  } tcr_bus_e;

  typedef struct packed
  {
    tcr_bus_e bus;
    logic [`TCR_DW-1:0] dat;
    logic [`TCR_BW-1:0] temp;
    logic [`TCR_NCH-1:0] status;
    logic [`TCR_NCH-1:0] mask;
  } tcr_top_s;

  typedef struct packed
  {
    logic [`TCR_CW-1:0] value;
    logic blank;
    logic match;
    logic pin;
  } tcr_chan_s;

endpackage

// >>> src/tcr_cmp_chan.sv
`timescale 1ns/1ps
`include "tcr_params.svh"

module tcr_cmp_chan
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timer side
  input wire logic [`TCR_CW-1:0] counter_value_i,
  input wire logic counter_tick_i,
  input wire logic counter_write_i,
  input wire logic pwm_mode_i,
  // Register side
  input wire logic force_compare_strobe_i,
  input wire logic wr_i,
  input wire logic [`TCR_CW-1:0] wr_value_i,
  // Results
  output logic [`TCR_CW-1:0] compare_value_o,
  output logic compare_match_o,
  output logic compare_output_pin_o
);

  tcr_pkg::tcr_chan_s st_q;
  tcr_pkg::tcr_chan_s st_d;
  logic equal;
  logic forced;

  always_comb
  begin
    st_d = st_q;
    equal = (counter_value_i == st_q.value);
    forced = force_compare_strobe_i & ~pwm_mode_i;
    // A counter write blanks the next timer clock only, not every later one.
    if (counter_write_i)
    begin
      st_d.blank = 1'b1;
    end
    else if (counter_tick_i)
    begin
      st_d.blank = 1'b0;
    end
    st_d.match = counter_tick_i & equal & ~st_q.blank;
    st_d.pin = st_q.pin ^ (st_d.match | forced);
    if (wr_i)
    begin
      st_d.value = wr_value_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '{value: `TCR_RST_VAL, blank: 1'b0, match: 1'b0, pin: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign compare_value_o = st_q.value;
  assign compare_match_o = st_q.match;
  assign compare_output_pin_o = st_q.pin;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  match_on_equal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (counter_tick_i && equal && !st_q.blank) |=> compare_match_o)
    else $error("equal counter did not raise a match");

  blank_after_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (counter_write_i ##1 (counter_tick_i && !counter_write_i)) |=> !compare_match_o)
    else $error("match seen on the tick after a counter write");

  force_no_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (forced && !(counter_tick_i && equal)) |=> (!compare_match_o
      && compare_output_pin_o != $past(compare_output_pin_o)))
    else $error("force strobe misbehaved");

endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`include "tcr_params.svh"

module tb_top;
  // ********************************************************************
  // Stimulus and design
  // ********************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [10:0] adr = 11'h000;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [`TCR_NTMR-1:0][`TCR_CW-1:0] cnt_v = '0;
  logic [3:0] tick = 4'h0, cwr = 4'h0, pwm = 4'h0;
  logic [11:0] pin, mat, exp_pin = 12'h0, exp_st = 12'h0, exp_mask = 12'h0;
  logic irq;
  logic [15:0] r, val [12];
  logic [31:0] expq [$];
  int error_cnt = 0, compares = 0, cycles = 0;
  logic [8:0] lo_i [12] = '{`TCR_T1A_LO, `TCR_T1B_LO, `TCR_T1C_LO, `TCR_T3A_LO, `TCR_T3B_LO,
    `TCR_T3C_LO, `TCR_T4A_LO, `TCR_T4B_LO, `TCR_T4C_LO, `TCR_T5A_LO, `TCR_T5B_LO, `TCR_T5C_LO};
  logic [8:0] hi_i [12] = '{`TCR_T1A_HI, `TCR_T1B_HI, `TCR_T1C_HI, `TCR_T3A_HI, `TCR_T3B_HI,
    `TCR_T3C_HI, `TCR_T4A_HI, `TCR_T4B_HI, `TCR_T4C_HI, `TCR_T5A_HI, `TCR_T5B_HI, `TCR_T5C_HI};

  always #10 clk_i = ~clk_i;

  tcr_top uut
  (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o), .ack_o(ack_o), .counter_value_i(cnt_v),
    .counter_tick_i(tick), .counter_write_i(cwr), .pwm_mode_i(pwm),
    .compare_output_pin_o(pin), .compare_match_o(mat), .irq_o(irq)
  );

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // A read pushes its expected data; the monitor pops it at the ack edge.
  task automatic wb(input logic w, input logic [8:0] idx, input logic [31:0] d,
    input logic [3:0] s = 4'h1);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= w ? d : 32'h0;
    sel <= s;
    if (!w)
      expq.push_back(d);
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic tick_chk(input int t, input logic [15:0] v, input logic [11:0] em);
    @(posedge clk_i);
    cnt_v[t] <= v;
    tick[t] <= 1'b1;
    cwr <= 4'h0;
    @(posedge clk_i);
    tick[t] <= 1'b0;
    #1;
    exp_pin = exp_pin ^ em;
    exp_st = exp_st | em;
    check({20'h0, mat}, {20'h0, em});
    check({20'h0, pin}, {20'h0, exp_pin});
    @(posedge clk_i);
    #1;
    check({20'h0, mat}, 32'h0);
    check({31'h0, irq}, {31'h0, |(exp_st & exp_mask)});
  endtask

  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we === 1'b0 && cyc === 1'b1)
    begin
      if (expq.size() == 0)
        check(dat_o, 32'hdead);
      else
        check(dat_o, expq.pop_front());
    end
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 12; k++)
    begin
      wb(1'b0, lo_i[k], 32'h0);
      wb(1'b0, hi_i[k], 32'h0);
    end
    wb(1'b0, `TCR_STAT_IDX, 32'h0);
    wb(1'b0, `TCR_MASK_IDX, 32'h0);
    wb(1'b1, 9'h1ff, 32'hff);
    wb(1'b0, 9'h1ff, 32'h0);
    $display("test reset values done");
    r = 16'h2a24;
    for (int k = 0; k < 12; k++)
    begin
      r = lfsr(r);
      val[k] = r;
      wb(1'b1, hi_i[k], {24'h0, r[15:8]});
      wb(1'b0, hi_i[k], 32'h0);
      wb(1'b1, lo_i[k], {24'h0, r[7:0]});
      wb(1'b0, hi_i[k], {24'h0, r[15:8]});
      wb(1'b0, lo_i[k], {24'h0, r[7:0]});
    end
    $display("test byte pairing done");
    // The latch is shared, so the second high write wins for channel 0.
    wb(1'b1, hi_i[0], 32'h5a);
    wb(1'b1, hi_i[7], 32'ha5);
    wb(1'b1, lo_i[0], {24'h0, val[0][7:0]});
    val[0][15:8] = 8'ha5;
    wb(1'b0, hi_i[0], 32'ha5);
    wb(1'b0, hi_i[7], {24'h0, val[7][15:8]});
    wb(1'b1, lo_i[1], 32'h33, 4'h0);
    wb(1'b0, lo_i[1], {24'h0, val[1][7:0]});
    $display("test shared latch done");
    wb(1'b1, `TCR_MASK_IDX, 32'hfff);
    exp_mask = 12'hfff;
    for (int k = 0; k < 12; k++)
      tick_chk(k / 3, val[k], 12'h001 << k);
    wb(1'b0, `TCR_STAT_IDX, 32'hfff);
    wb(1'b1, `TCR_MASK_IDX, 32'h0);
    exp_mask = 12'h0;
    #1 check({31'h0, irq}, 32'h0);
    wb(1'b1, `TCR_STAT_IDX, 32'h00f);
    exp_st = 12'hff0;
    wb(1'b0, `TCR_STAT_IDX, 32'hff0);
    wb(1'b1, `TCR_MASK_IDX, 32'h0f0);
    exp_mask = 12'h0f0;
    #1 check({31'h0, irq}, 32'h1);
    $display("test match and interrupt done");
    for (int t = 0; t < 4; t++)
    begin
      @(posedge clk_i);
      cwr[t] <= 1'b1;
      // Even timers tick right after the write, odd ones after an idle cycle.
      if (t % 2 == 1)
      begin
        @(posedge clk_i);
        cwr[t] <= 1'b0;
      end
      tick_chk(t, val[3 * t], 12'h0);
      tick_chk(t, val[3 * t], 12'h001 << (3 * t));
    end
    $display("test counter write blanking done");
    wb(1'b1, `TCR_STAT_IDX, 32'hfff);
    exp_st = 12'h0;
    wb(1'b1, `TCR_FORCE_IDX, 32'hfff);
    @(posedge clk_i);
    #1;
    exp_pin = ~exp_pin;
    check({20'h0, pin}, {20'h0, exp_pin});
    wb(1'b0, `TCR_STAT_IDX, 32'h0);
    pwm <= 4'hf;
    wb(1'b1, `TCR_FORCE_IDX, 32'hfff);
    @(posedge clk_i);
    #1 check({20'h0, pin}, {20'h0, exp_pin});
    wb(1'b0, `TCR_FORCE_IDX, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test force strobe done");
    close_out();
  end
endmodule
